/* dv/tmr_ext_model.sv */
// Model of the count input pin and of the watchdog side feeding the shared prescaler.
// Assumes the bench calls its tasks from one process clocked by the same clk.
`timescale 1ns/10ps

module tmr_ext_model (
   input  wire logic clk,
   output      logic ext_count_input,
   output      logic watchdog_tick,
   output      logic watchdog_clear_instr
);
   initial begin
      ext_count_input = 1'b0;
      watchdog_tick = 1'b0;
      watchdog_clear_instr = 1'b0;
   end

   // Each level is held four cycles so that no edge is lost in the synchroniser.
   task automatic toggle_pin(input int n);
      repeat (n) begin
         @(posedge clk);
         ext_count_input <= ~ext_count_input;
         repeat (3) @(posedge clk);
      end
   endtask : toggle_pin

   task automatic wd_ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         watchdog_tick <= 1'b1;
         @(posedge clk);
         watchdog_tick <= 1'b0;
      end
   endtask : wd_ticks

   task automatic wd_clear;
      @(posedge clk);
      watchdog_clear_instr <= 1'b1;
      @(posedge clk);
      watchdog_clear_instr <= 1'b0;
   endtask : wd_clear
endmodule : tmr_ext_model

/* dv/tmr_timer0_tb_top.sv */
// Self-checking bench: register accesses over Avalon-MM and checks against expected values.
// Assumes the pin and watchdog model; each bus access lasts until waitrequest drops.
`timescale 1ns/10ps

module tmr_timer0_tb_top;
   import tmr_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        ext_count_input;
   logic        watchdog_tick;
   logic        watchdog_clear_instr;
   logic        watchdog_prescaled_tick;
   logic        irq;
   logic [31:0] rd;
   logic [31:0] rd2;
   int          bad_count = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          wd_pulses = 0;
   int          p;
   logic [4:0]  addrs [6] = '{TMR_OFF_COUNT, TMR_OFF_CONFIG, TMR_OFF_STATUS,
                               TMR_OFF_CLEAR, TMR_OFF_ENABLE, 5'h14};
   logic [7:0]  rstv [6] = '{TMR_COUNT_RST, TMR_CONFIG_RST, TMR_IRQ_RST, 8'h00, TMR_IRQ_RST, 8'h00};

   always #4 clk = ~clk;

   tmr_timer0 tmr_timer0_i (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ext_count_input(ext_count_input),
      .watchdog_tick(watchdog_tick), .watchdog_clear_instr(watchdog_clear_instr),
      .watchdog_prescaled_tick(watchdog_prescaled_tick), .irq(irq));

   tmr_ext_model tmr_ext_model_i (.clk(clk), .ext_count_input(ext_count_input),
      .watchdog_tick(watchdog_tick), .watchdog_clear_instr(watchdog_clear_instr));

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   always @(posedge clk) begin
      cycles++;
      if (watchdog_prescaled_tick === 1'b1) wd_pulses++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // The request stands until waitrequest is sampled low; read data is taken at that edge.
   task automatic bus(input logic wr, input logic [4:0] addr, input logic [7:0] data);
      @(posedge clk);
      avs_address <= addr;
      avs_writedata <= {24'h00_0000, data};
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      foreach (addrs[i]) begin
         bus(0, addrs[i], 8'h00);
         check("reset value", rd[7:0], rstv[i]);
      end
      avs_byteenable <= 4'h0;
      bus(1, TMR_OFF_CONFIG, 8'h00);
      avs_byteenable <= 4'hF;
      bus(1, 5'h14, 8'hFF);
      bus(0, TMR_OFF_CONFIG, 8'h00);
      check("config", rd[7:0], 8'hFF);
      bus(1, TMR_OFF_CONFIG, 8'h08);
      bus(1, TMR_OFF_COUNT, 8'h10);
      bus(0, TMR_OFF_COUNT, 8'h00);
      check("count held", rd[7:0], 8'h10);
      bus(0, TMR_OFF_COUNT, 8'h00);
      check("count 1:1", rd[7:0], 8'h12);
      // Two reads 256 cycles apart give a step that does not depend on prescaler phase.
      for (int n = 0; n < 8; n++) begin
         bus(1, TMR_OFF_CONFIG, 8'(n));
         bus(0, TMR_OFF_COUNT, 8'h00);
         rd2 = rd;
         repeat (253) @(posedge clk);
         bus(0, TMR_OFF_COUNT, 8'h00);
         check("count step", rd[7:0] - rd2[7:0], 8'(128 >> n));
      end
      bus(1, TMR_OFF_COUNT, 8'h00);
      repeat (200) @(posedge clk);
      bus(1, TMR_OFF_COUNT, 8'h00);
      repeat (200) @(posedge clk);
      bus(0, TMR_OFF_COUNT, 8'h00);
      check("prescaler cleared", rd[7:0], 8'h00);
      tmr_ext_model_i.wd_clear();
      bus(1, TMR_OFF_COUNT, 8'h00);
      bus(1, TMR_OFF_CONFIG, 8'h0F);
      tmr_ext_model_i.wd_clear();
      for (int n = 0; n < 4; n++) begin
         bus(1, TMR_OFF_CONFIG, 8'h28 | 8'(n));
         tmr_ext_model_i.wd_clear();
         p = wd_pulses;
         tmr_ext_model_i.wd_ticks(16);
         repeat (4) @(posedge clk);
         check("wd pulses", 8'(wd_pulses - p), 8'(16 >> n));
      end
      bus(1, TMR_OFF_CONFIG, 8'h2A);
      tmr_ext_model_i.wd_clear();
      p = wd_pulses;
      tmr_ext_model_i.wd_ticks(2);
      tmr_ext_model_i.wd_clear();
      tmr_ext_model_i.wd_ticks(2);
      repeat (4) @(posedge clk);
      check("wd after clear", 8'(wd_pulses - p), 8'h00);
      bus(1, TMR_OFF_COUNT, 8'h00);
      tmr_ext_model_i.toggle_pin(5);
      repeat (6) @(posedge clk);
      bus(0, TMR_OFF_COUNT, 8'h00);
      check("rising edges", rd[7:0], 8'h03);
      bus(1, TMR_OFF_CONFIG, 8'h38);
      bus(1, TMR_OFF_COUNT, 8'h00);
      tmr_ext_model_i.toggle_pin(3);
      repeat (6) @(posedge clk);
      bus(0, TMR_OFF_COUNT, 8'h00);
      check("falling edges", rd[7:0], 8'h02);
      bus(1, TMR_OFF_CONFIG, 8'h20);
      bus(1, TMR_OFF_COUNT, 8'h00);
      tmr_ext_model_i.toggle_pin(8);
      repeat (6) @(posedge clk);
      bus(0, TMR_OFF_COUNT, 8'h00);
      check("prescaled edges", rd[7:0], 8'h02);
      bus(1, TMR_OFF_CONFIG, 8'h08);
      bus(1, TMR_OFF_ENABLE, 8'h04);
      bus(1, TMR_OFF_COUNT, 8'hFE);
      repeat (4) @(posedge clk);
      bus(1, TMR_OFF_CONFIG, 8'h28);
      bus(0, TMR_OFF_STATUS, 8'h00);
      check("flag set", rd[7:0], 8'h04);
      check("irq on", {7'h00, irq}, 8'h01);
      bus(1, TMR_OFF_ENABLE, 8'h00);
      repeat (2) @(posedge clk);
      check("irq masked", {7'h00, irq}, 8'h00);
      bus(1, TMR_OFF_STATUS, 8'h00);
      bus(0, TMR_OFF_STATUS, 8'h00);
      check("flag sticky", rd[7:0], 8'h04);
      bus(1, TMR_OFF_CLEAR, 8'h04);
      bus(0, TMR_OFF_STATUS, 8'h00);
      check("flag cleared", rd[7:0], 8'h00);
      bus(0, TMR_OFF_CLEAR, 8'h00);
      check("clear reads", rd[7:0], 8'h00);
      // A second reset in mid-run must bring back the reset values.
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      bus(0, TMR_OFF_CONFIG, 8'h00);
      check("config after reset", rd[7:0], TMR_CONFIG_RST);
      bus(0, TMR_OFF_COUNT, 8'h00);
      check("count after reset", rd[7:0], TMR_COUNT_RST);
      end_of_test();
   end
endmodule : tmr_timer0_tb_top

/* rtl/tmr_timer0.sv */
// 8-bit timer/counter with a prescaler shared with the watchdog, on an Avalon-MM slave.
// Assumes one clk cycle is one instruction cycle and that the watchdog base tick
// and the watchdog clear pulse are synchronous to clk; the external count input may be asynchronous.
// How it works
// - Eight-bit count, readable, writable, counts upward.
// - Timer mode counts every instruction cycle.
// - Count write blocks counting two cycles.
// - Counter mode counts selected external input edges.
// - Edge select one: falling, zero: rising.
// - One prescaler, serving timer or watchdog.
// - Assign bit zero gives prescaler to timer.
// - Timer ratios 1:2 to 1:256.
// - Rate n: timer 2^(n+1), watchdog 2^n.
// - Undivided timer only with prescaler on watchdog.
// - Prescaler count hidden from software.
// - Count write clears prescaler when timer-assigned.
// - Watchdog clear clears prescaler when watchdog-assigned.
// - Wrap to zero sets sticky overflow flag.
`timescale 1ns/10ps

module tmr_timer0 (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output      logic [31:0] avs_readdata,
   output      logic        avs_waitrequest,
   input  wire logic        ext_count_input,
   input  wire logic        watchdog_tick,
   input  wire logic        watchdog_clear_instr,
   output      logic        watchdog_prescaled_tick,
   output      logic        irq
);
   import tmr_pkg::*;

   // Register state.
   logic [7:0]   timer_count_reg;
   logic [7:0]   timer_count_next;
   tmr_config_t  timer_config_reg;
   logic [7:0]   presc_reg;
   logic [7:0]   presc_next;
   logic         overflow_flag_reg;
   logic         overflow_flag_next;
   logic         overflow_irq_enable_reg;
   tmr_inhibit_t inhibit_reg;
   tmr_inhibit_t inhibit_next;
   logic         sync1_reg;
   logic         sync2_reg;
   logic         sync3_reg;
   logic         wait_reg;
   logic [31:0]  rdata_reg;
   logic         irq_reg;
   logic         wdt_out_reg;

   // Bus decode.
   wire          req;
   wire          accept;
   wire          wr_ok;
   wire          sel_count;
   wire          sel_config;
   wire          sel_status;
   wire          sel_clear;
   wire          sel_enable;
   wire          count_wr;
   wire          config_wr;
   wire          clear_wr;
   wire          enable_wr;
   wire [7:0]    wbyte;
   wire [7:0]    status_view;
   wire [7:0]    enable_view;
   wire [31:0]   rdata_mux;

   // Count path.
   wire          rise_seen;
   wire          fall_seen;
   wire          ext_edge;
   wire          src_tick;
   wire [7:0]    timer_mask;
   wire [7:0]    wdt_mask;
   wire          timer_on_presc;
   wire          presc_in_tick;
   wire          presc_clr;
   wire          presc_full_timer;
   wire          presc_full_wdt;
   wire          timer_tick;
   wire          wrap;

   // Low bits set, as many as the argument: the prescaler reaches the end of a 2^bits cycle.
   function automatic logic [7:0] ones_mask(input logic [3:0] bits);
      ones_mask = 8'((16'h0001 << bits) - 16'h0001);
   endfunction : ones_mask

   assign req        = avs_read | avs_write;
   assign accept     = req & ~wait_reg;
   assign wr_ok      = accept & avs_write & avs_byteenable[0];
   assign sel_count  = (avs_address == TMR_OFF_COUNT);
   assign sel_config = (avs_address == TMR_OFF_CONFIG);
   assign sel_status = (avs_address == TMR_OFF_STATUS);
   assign sel_clear  = (avs_address == TMR_OFF_CLEAR);
   assign sel_enable = (avs_address == TMR_OFF_ENABLE);
   assign count_wr   = wr_ok & sel_count;
   assign config_wr  = wr_ok & sel_config;
   assign clear_wr   = wr_ok & sel_clear;
   assign enable_wr  = wr_ok & sel_enable;
   assign wbyte      = avs_writedata[7:0];

   assign status_view = 8'(overflow_flag_reg) << TMR_OVF_BIT;
   assign enable_view = 8'(overflow_irq_enable_reg) << TMR_OVF_BIT;

   // The prescaler never appears on the read path.
   assign rdata_mux = sel_count  ? {24'h00_0000, timer_count_reg} :
                      sel_config ? {24'h00_0000, timer_config_reg} :
                      sel_status ? {24'h00_0000, status_view} :
                      sel_enable ? {24'h00_0000, enable_view} :
                      32'h0000_0000;

   // Edge detection reads only the second and third stages.
   assign rise_seen = sync2_reg & ~sync3_reg;
   assign fall_seen = ~sync2_reg & sync3_reg;
   assign ext_edge  = timer_config_reg.source_edge_select ? fall_seen : rise_seen;
   assign src_tick  = timer_config_reg.count_source_select ? ext_edge : 1'b1;

   assign timer_on_presc = ~timer_config_reg.prescaler_assign;
   assign timer_mask     = ones_mask({1'b0, timer_config_reg.prescale_rate} + 4'h1);
   assign wdt_mask       = ones_mask({1'b0, timer_config_reg.prescale_rate});

   // One counter, fed by one source at a time.
   assign presc_in_tick    = timer_on_presc ? src_tick : watchdog_tick;
   assign presc_full_timer = (presc_reg & timer_mask) == timer_mask;
   assign presc_full_wdt   = (presc_reg & wdt_mask) == wdt_mask;
   assign presc_clr        = timer_on_presc ? count_wr : watchdog_clear_instr;

   // Without the prescaler the timer takes every source tick.
   assign timer_tick = (inhibit_reg == TMR_INH_IDLE) &
                       (timer_on_presc ? (src_tick & presc_full_timer) : src_tick);
   assign wrap       = timer_tick & (timer_count_reg == TMR_COUNT_MAX);

   // The write clear beats a tick in the same cycle, so the ratio restarts from the write.
   assign presc_next = presc_clr     ? 8'h00 :
                       presc_in_tick ? presc_reg + 8'h01 :
                       presc_reg;

   // A software write of the count takes priority over a tick in the same cycle.
   assign timer_count_next = count_wr   ? wbyte :
                             timer_tick ? timer_count_reg + 8'h01 :
                             timer_count_reg;

   // A wrap in the clearing cycle keeps the flag set.
   assign overflow_flag_next = wrap ? 1'b1 :
                               (clear_wr & wbyte[TMR_OVF_BIT]) ? 1'b0 :
                               overflow_flag_reg;

   always_comb begin
      inhibit_next = inhibit_reg;
      case (inhibit_reg)
         TMR_INH_IDLE:  inhibit_next = TMR_INH_IDLE;
         TMR_INH_HOLD2: inhibit_next = TMR_INH_HOLD1;
         TMR_INH_HOLD1: inhibit_next = TMR_INH_IDLE;
         default:       inhibit_next = TMR_INH_IDLE;
      endcase
      if (count_wr) begin
         inhibit_next = TMR_INH_HOLD2;
      end
   end

   // Bus handshake: every request is answered at the second edge.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         wait_reg  <= ~(req & wait_reg);
         rdata_reg <= (avs_read & wait_reg) ? rdata_mux : rdata_reg;
      end
   end

   // Bits 7:6 are stored only; nothing in this block uses them.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timer_config_reg        <= TMR_CONFIG_RST;
         overflow_irq_enable_reg <= 1'b0;
      end else begin
         timer_config_reg        <= config_wr ? tmr_config_t'(wbyte) : timer_config_reg;
         overflow_irq_enable_reg <= enable_wr ? wbyte[TMR_OVF_BIT] : overflow_irq_enable_reg;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timer_count_reg   <= TMR_COUNT_RST;
         presc_reg         <= 8'h00;
         overflow_flag_reg <= 1'b0;
         inhibit_reg       <= TMR_INH_IDLE;
      end else begin
         timer_count_reg   <= timer_count_next;
         presc_reg         <= presc_next;
         overflow_flag_reg <= overflow_flag_next;
         inhibit_reg       <= inhibit_next;
      end
   end

   // The first stage may go metastable, so only the later two feed the edge detector.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
      end else begin
         sync1_reg <= ext_count_input;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // Outputs from flip-flops; the interrupt follows the flag one cycle later.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_reg     <= 1'b0;
         wdt_out_reg <= 1'b0;
      end else begin
         irq_reg     <= overflow_flag_reg & overflow_irq_enable_reg;
         wdt_out_reg <= ~timer_on_presc & watchdog_tick & presc_full_wdt & ~presc_clr;
      end
   end

   assign avs_waitrequest         = wait_reg;
   assign avs_readdata            = rdata_reg;
   assign irq                     = irq_reg;
   assign watchdog_prescaled_tick = wdt_out_reg;

   // Checks.
   // Properties are sampled on clk and switched off while reset is held.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_count_write;
      count_wr;
   endsequence

   sequence s_held_two;
      (timer_count_reg == $past(wbyte)) ##1 $stable(timer_count_reg)
         ##1 $stable(timer_count_reg);
   endsequence

   sequence s_answer_pulse;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   a_count_write_hold: assert property (s_count_write |=> s_held_two)
      else $error("Count moved during the post-write hold.");

   a_overflow_sets_flag: assert property (wrap && !count_wr |=>
      overflow_flag_reg && timer_count_reg == TMR_COUNT_RST)
      else $error("Wrap did not set the overflow flag.");

   a_flag_sticky: assert property (overflow_flag_reg && !clear_wr |=> overflow_flag_reg)
      else $error("Overflow flag dropped without a clear.");

   a_timer_undivided: assert property (!timer_config_reg.count_source_select &&
      timer_config_reg.prescaler_assign && inhibit_reg == TMR_INH_IDLE && !count_wr
      |=> timer_count_reg == $past(timer_count_reg) + 8'h01)
      else $error("Undivided timer mode did not advance by one.");

   a_presc_clear_write: assert property (timer_on_presc && count_wr |=> presc_reg == 8'h00)
      else $error("Count write did not clear the prescaler.");

   a_presc_clear_wdt: assert property (!timer_on_presc && watchdog_clear_instr
      |=> presc_reg == 8'h00)
      else $error("Watchdog clear did not clear the prescaler.");

   a_fall_edge_counts: assert property (timer_config_reg.count_source_select &&
      timer_config_reg.source_edge_select && $fell(sync2_reg) |-> src_tick)
      else $error("Falling edge not counted.");

   // After a timer tick the low prescaler bits restart, so the next tick is a full period away.
   a_timer_ratio: assert property (timer_on_presc && timer_tick |=>
      (presc_reg & $past(timer_mask)) == 8'h00)
      else $error("Timer ticked before the prescaler filled.");

   a_irq_follows_flag: assert property (overflow_flag_reg && overflow_irq_enable_reg
      |=> irq)
      else $error("Enabled overflow did not raise the interrupt.");

   a_bus_answer: assert property (req && wait_reg |=> s_answer_pulse)
      else $error("Bus request not answered on the second edge.");

   // The hold states alone must freeze the count; only a fresh write may move it.
   a_hold_no_count: assert property (inhibit_reg != TMR_INH_IDLE && !count_wr
      |=> $stable(timer_count_reg))
      else $error("Count advanced inside the post-write hold.");

   a_timer_mode_tick: assert property (!timer_config_reg.count_source_select
      |-> src_tick)
      else $error("Timer mode lost an instruction-cycle tick.");

   a_rise_edge_counts: assert property (timer_config_reg.count_source_select &&
      !timer_config_reg.source_edge_select && $rose(sync2_reg) |-> src_tick)
      else $error("Rising edge not counted.");

   // A steady pin must never count, whatever the edge select says.
   a_quiet_pin: assert property (timer_config_reg.count_source_select &&
      $stable(sync2_reg) |-> !src_tick)
      else $error("Counter mode counted without a pin edge.");

   a_config_write: assert property (config_wr |=> timer_config_reg == $past(wbyte))
      else $error("Configuration write did not land.");

   // Each side of the shared prescaler must leave it alone while the other owns it.
   a_presc_wdt_only: assert property (!timer_on_presc && !watchdog_tick &&
      !watchdog_clear_instr |=> $stable(presc_reg))
      else $error("Prescaler moved without a watchdog tick.");

   a_presc_timer_only: assert property (timer_on_presc && !src_tick && !count_wr
      |=> $stable(presc_reg))
      else $error("Prescaler moved without a timer source tick.");

   a_wdt_quiet: assert property (timer_on_presc |=> !watchdog_prescaled_tick)
      else $error("Watchdog tick while the prescaler serves the timer.");

   a_wdt_from_tick: assert property (watchdog_prescaled_tick |-> $past(watchdog_tick))
      else $error("Prescaled watchdog tick without a base tick.");

   a_flag_clear: assert property (clear_wr && wbyte[TMR_OVF_BIT] && !wrap
      |=> !overflow_flag_reg)
      else $error("Clear did not drop the overflow flag.");

   a_status_read_only: assert property (wr_ok && sel_status && !wrap
      |=> overflow_flag_reg == $past(overflow_flag_reg))
      else $error("Status write changed the overflow flag.");

   a_irq_quiet: assert property (!(overflow_flag_reg && overflow_irq_enable_reg)
      |=> !irq)
      else $error("Interrupt raised without an enabled overflow.");

   a_count_idle: assert property (!timer_tick && !count_wr |=> $stable(timer_count_reg))
      else $error("Count moved without a tick or a write.");

   // Upper read lanes are always zero so software may read the whole word.
   a_read_pad: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
      else $error("Read data upper lanes not zero.");

endmodule : tmr_timer0

/* shared/tmr_pkg.sv */
// Constants, register map and field layouts of the timer/counter with shared prescaler.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and one aligned word per register.
package tmr_pkg;

   // Register byte offsets.
   localparam logic [4:0] TMR_OFF_COUNT  = 5'h00;
   localparam logic [4:0] TMR_OFF_CONFIG = 5'h04;
   localparam logic [4:0] TMR_OFF_STATUS = 5'h08;
   localparam logic [4:0] TMR_OFF_CLEAR  = 5'h0C;
   localparam logic [4:0] TMR_OFF_ENABLE = 5'h10;

   // Reset values and the top count value.
   localparam logic [7:0] TMR_CONFIG_RST = 8'hFF;
   localparam logic [7:0] TMR_COUNT_RST  = 8'h00;
   localparam logic [7:0] TMR_COUNT_MAX  = 8'hFF;
   localparam logic [7:0] TMR_IRQ_RST    = 8'h00;

   // Position of the overflow flag in status, clear and enable registers.
   localparam int unsigned TMR_OVF_BIT = 2;

   // Mask that keeps the low byte of the data bus.
   localparam logic [31:0] TMR_BYTE_MASK = 32'h0000_00FF;

   // Field layout of the configuration register.
   typedef struct packed {
      logic       pullup_disable;
      logic       int_edge;
      logic       count_source_select;
      logic       source_edge_select;
      logic       prescaler_assign;
      logic [2:0] prescale_rate;
   } tmr_config_t;

   // Write-blocking sequencer after a count register write.
   typedef enum logic [1:0] {
      TMR_INH_IDLE  = 2'b00,
      TMR_INH_HOLD1 = 2'b01,
      TMR_INH_HOLD2 = 2'b10
   } tmr_inhibit_t;

endpackage : tmr_pkg
